// *** rtl/ocs_pkg.sv ***
// Shared constants, types and helpers for the configuration source loader.
// Assumes a 25 MHz system clock and a 16 MHz oscillator tick from the same
// clock domain.
package ocs_pkg;
  // Fuse array shape: banks of fuse bits, one shadow word per bank
  localparam int BANKS = 10;
  localparam int BANK_BITS = 26;
  localparam int AW = 4;
  localparam logic [AW-1:0] LAST_BANK = AW'(BANKS - 1);

  // System clock, for reference
  localparam int CLK_HZ = 25_000_000;

  // Oscillator and derived rates
  localparam int OSC_HZ = 16_000_000;
  localparam int CLK2M_HZ = 2_000_000;
  localparam int TB_HZ = 32_000;
  localparam int DIV_W = 9;
  localparam logic [DIV_W-1:0] TWO_LAST = DIV_W'(OSC_HZ / CLK2M_HZ - 1);
  localparam logic [DIV_W-1:0] TB_LAST = DIV_W'(OSC_HZ / TB_HZ - 1);

  // Power button hold time, in seconds, and its count of time base ticks
  localparam int HOLD_SEC = 4;
  localparam int HOLD_TICKS = HOLD_SEC * TB_HZ;
  localparam int HOLD_W = 17;

  // Factory default pattern; arbitrary neutral value
  localparam logic [BANK_BITS-1:0] DEFAULT_SEED = 26'h2a5_a5a5;
  localparam logic [BANK_BITS-1:0] ZERO_WORD = '0;

  // Positions of the pins in the synchroniser vector
  localparam int SYNC_W = 5;
  localparam int PIN_VIN = 0;
  localparam int PIN_UV = 1;
  localparam int PIN_FUSESUP = 2;
  localparam int PIN_BUTTON = 3;
  localparam int PIN_SLOWOSC = 4;
  localparam logic [SYNC_W-1:0] SYNC_RST = 5'h08;

  // Loader states
  typedef enum logic [2:0] {
    ST_WAITVIN, ST_EVAL, ST_FUSE, ST_DEF, ST_READY, ST_ON
  } ocs_state_t;

  // Configuration source
  typedef enum logic [1:0] {
    SRC_NONE, SRC_FUSE, SRC_SHADOW, SRC_DEFAULT
  } ocs_src_t;

  // Combined fuse-load flag for both silicon variants
  function automatic logic fuse_load_enabled(input logic [2:0] f,
                                             input logic revised);
    fuse_load_enabled = revised ? &f : ^f;
  endfunction : fuse_load_enabled

  // Factory default word of one bank
  function automatic logic [BANK_BITS-1:0] default_word(
      input logic [AW-1:0] idx);
    default_word = DEFAULT_SEED ^ {{(BANK_BITS - AW){1'b0}}, idx};
  endfunction : default_word
endpackage : ocs_pkg

// *** rtl/ocs_btn_if.sv ***
// Carrier between the loader and its power button unit.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface ocs_btn_if;
  logic tick; // Debounce time base tick
  logic edgeMode; // Edge-sensitive button mode
  logic pinLevel; // Synchronised power-on pin
  logic turnOn; // Turn-on event pulse
  logic turnOff; // Turn-off event pulse
  modport ctrl (output tick, edgeMode, pinLevel, input turnOn, turnOff);
  modport btn (input tick, edgeMode, pinLevel, output turnOn, turnOff);
endinterface : ocs_btn_if
`default_nettype wire

// *** rtl/ocs_button.sv ***
// Power button event detector: level or edge mode, long-hold turn-off in edge mode.
// Assumes the pin level is already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
module ocs_button
  import ocs_pkg::*;
#(
  parameter int HOLD = HOLD_TICKS
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Link to the loader
  ocs_btn_if.btn bi
);
  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD - 1);
  localparam logic [HOLD_W-1:0] HOLD_FULL = HOLD_W'(HOLD);

  logic lastLevel_reg; // Pin level one cycle ago
  logic [HOLD_W-1:0] holdCnt_reg; // Ticks seen while held low

  // Previous level, idle high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lastLevel_reg <= 1'b1;
    end else if (ce) begin
      lastLevel_reg <= bi.pinLevel;
    end
  end

  // Low-time counter, saturates at the hold count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      holdCnt_reg <= '0;
    end else if (ce) begin
      if (bi.pinLevel) begin
        holdCnt_reg <= '0;
      end else if (bi.tick && holdCnt_reg != HOLD_FULL) begin
        holdCnt_reg <= holdCnt_reg + 1'b1;
      end
    end
  end

  // Turn-on and turn-off pulses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bi.turnOn <= 1'b0;
      bi.turnOff <= 1'b0;
    end else if (ce) begin
      if (bi.edgeMode) begin
        // Falling edge starts, long hold stops
        bi.turnOn <= lastLevel_reg && !bi.pinLevel;
        bi.turnOff <= !bi.pinLevel && bi.tick
                      && holdCnt_reg == HOLD_LAST;
      end else begin
        // High means on, low means off
        bi.turnOn <= !lastLevel_reg && bi.pinLevel;
        bi.turnOff <= lastLevel_reg && !bi.pinLevel;
      end
    end
  end

  // Long-hold turn-off only after the full hold count
  a_hold_off_count: assert property (@(posedge clk) disable iff (rst)
    (bi.turnOff && $past(bi.edgeMode) && $past(ce))
      |-> $past(holdCnt_reg) == HOLD_LAST)
    else $error("turn-off before the hold time");
endmodule : ocs_button
`default_nettype wire

// *** rtl/ocs_loader.sv ***
// Start-up configuration loader: picks the shadow register source, loads
// it, powers on at a turn-on event, and makes the 2 MHz and 32 kHz ticks.
// Assumes pins are asynchronous; flags, host port, fuse port and the
// 16 MHz oscillator tick come from logic on clk.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Shadow registers start at zero on supply
// - Fuse supply high loads factory defaults
// - Grounded, keep clear, flag set: load fuses
// - Original variant: flag is XOR of three
// - Revised variant: all three flags needed
// - Grounded, both flags clear: shadow stays zero
// - Keep flag resets zero, set keeps shadow
// - Host may write the shadow registers
// - Shadow power-up needs supply, ground, keep, event
// - Error-corrected fuse values may be loaded
// - After fuse load, turn-on uses fuses
// - Ten fuse banks of twenty-six bits
// - Untrimmed clock only under UV, sleep, PFM
// - Derived 32 kHz for start-up and debounce
// - IRQ debounce derived while oscillator on; two IRQs untrimmed
// - 2 MHz divided from 16 MHz
// - Edge mode: fall starts, 4 s hold stops
module ocs_loader
  import ocs_pkg::*;
#(
  parameter int HOLD = HOLD_TICKS
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Asynchronous pins
  input wire logic vinValidPin,
  input wire logic belowUvPin,
  input wire logic fuseSupplyPin,
  input wire logic powerOnPin,
  input wire logic slowOscPin,
  // Oscillator tick and operating state
  input wire logic osc16Tick,
  input wire logic osc16OnMode,
  input wire logic allSleep,
  input wire logic allPfm,
  // Configuration flags
  input wire logic keepShadowFlag,
  input wire logic fuseLoadFlagOne,
  input wire logic fuseLoadFlagTwo,
  input wire logic fuseLoadFlagThree,
  input wire logic revisedVariant,
  input wire logic buttonEdgeModeSelect,
  input wire logic eccEnabled,
  // Host shadow register port
  input wire logic hostWrEn,
  input wire logic [AW-1:0] hostAddr,
  input wire logic [BANK_BITS-1:0] hostWrData,
  output logic [BANK_BITS-1:0] hostRdData,
  // Fuse array read port
  output logic [AW-1:0] fuseAddr,
  input wire logic [BANK_BITS-1:0] fuseRawData,
  input wire logic [BANK_BITS-1:0] fuseEccData,
  // Status
  output logic [1:0] configSource,
  output logic loadBusy,
  output logic poweredOn,
  // Time bases
  output logic clk2mTick,
  output logic derivedTick,
  output logic untrimmedTick,
  output logic mainTick,
  output logic irqDebTick,
  output logic slowIrqTick
);
  // Pin synchroniser stages
  logic [SYNC_W-1:0] syncA_reg; // First stage, read only by second
  logic [SYNC_W-1:0] syncB_reg; // Second stage, safe to use
  logic slowLast_reg; // Previous slow oscillator level

  // Dividers and tick flops
  logic [DIV_W-1:0] div2m_reg; // 16 MHz to 2 MHz
  logic [DIV_W-1:0] divTb_reg; // 16 MHz to 32 kHz
  logic clk2m_reg;
  logic derived_reg;
  logic untrimmed_reg;
  logic main_reg;
  logic irqDeb_reg;
  logic slowIrq_reg;

  // Loader state
  ocs_state_t state_reg; // Sequencer state
  ocs_src_t src_reg; // Source in the shadow registers
  logic [AW-1:0] idx_reg; // Bank being loaded
  logic pendingOn_reg; // Turn-on waiting for the load
  logic powered_reg; // Powered-on level
  logic busy_reg; // Bank load in progress
  logic firstEval_reg; // Evaluated at least once
  logic [BANK_BITS-1:0] shadowMem [BANKS]; // Shadow registers
  logic [BANK_BITS-1:0] rdData_reg; // Host readback

  // Derived conditions
  logic vinOk; // Synchronised supply valid
  logic fuseHigh; // Fuse supply at core rail level
  logic fuseFlag; // Combined fuse-load flag
  logic useUntrimmed; // Slow untrimmed clock selected
  logic slowEdge; // Untrimmed oscillator rising edge
  logic hostOpen; // Host writes accepted
  logic btnOn;
  logic btnOff;

  ocs_btn_if bif ();

  assign vinOk = syncB_reg[PIN_VIN];
  assign fuseHigh = syncB_reg[PIN_FUSESUP];
  assign fuseFlag = fuse_load_enabled(
    {fuseLoadFlagThree, fuseLoadFlagTwo, fuseLoadFlagOne}, revisedVariant);
  assign useUntrimmed = syncB_reg[PIN_UV] || allSleep || allPfm;
  assign slowEdge = syncB_reg[PIN_SLOWOSC] && !slowLast_reg;
  assign hostOpen = state_reg == ST_READY || state_reg == ST_ON;
  assign btnOn = bif.turnOn;
  assign btnOff = bif.turnOff;

  // Button unit wiring; edge mode debounces on the derived base
  assign bif.tick = buttonEdgeModeSelect ? derived_reg : main_reg;
  assign bif.edgeMode = buttonEdgeModeSelect;
  assign bif.pinLevel = syncB_reg[PIN_BUTTON];

  ocs_button #(
    .HOLD(HOLD)
  ) u_button (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .bi(bif.btn)
  );

  // Two-flop synchroniser for every pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA_reg <= SYNC_RST;
      syncB_reg <= SYNC_RST;
      slowLast_reg <= 1'b0;
    end else if (ce) begin
      syncA_reg <= {slowOscPin, powerOnPin, fuseSupplyPin, belowUvPin,
                    vinValidPin};
      syncB_reg <= syncA_reg;
      slowLast_reg <= syncB_reg[PIN_SLOWOSC];
    end
  end

  // Oscillator dividers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div2m_reg <= '0;
      divTb_reg <= '0;
    end else if (ce && osc16Tick) begin
      div2m_reg <= (div2m_reg == TWO_LAST) ? '0 : div2m_reg + 1'b1;
      divTb_reg <= (divTb_reg == TB_LAST) ? '0 : divTb_reg + 1'b1;
    end
  end

  // Tick outputs and time base selection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk2m_reg <= 1'b0;
      derived_reg <= 1'b0;
      untrimmed_reg <= 1'b0;
      main_reg <= 1'b0;
      irqDeb_reg <= 1'b0;
      slowIrq_reg <= 1'b0;
    end else if (ce) begin
      // 2 MHz from the 16 MHz oscillator
      clk2m_reg <= osc16Tick && div2m_reg == TWO_LAST;
      // Accurate 32 kHz from the 16 MHz oscillator
      derived_reg <= osc16Tick && divTb_reg == TB_LAST;
      untrimmed_reg <= slowEdge;
      // Untrimmed only in the low-power cases
      main_reg <= useUntrimmed ? slowEdge
                               : (osc16Tick && divTb_reg == TB_LAST);
      // Debounce base while the oscillator is on
      irqDeb_reg <= osc16OnMode ? (osc16Tick && divTb_reg == TB_LAST)
                                : slowEdge;
      // Low-input and button interrupts stay on untrimmed
      slowIrq_reg <= slowEdge;
    end
  end

  // Source selection and power sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_WAITVIN;
      src_reg <= SRC_NONE;
      idx_reg <= '0;
      pendingOn_reg <= 1'b0;
      powered_reg <= 1'b0;
      firstEval_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else if (ce) begin
      if (!vinOk) begin
        // Supply lost: off, wait for it again
        state_reg <= ST_WAITVIN;
        busy_reg <= 1'b0;
        powered_reg <= 1'b0;
        pendingOn_reg <= 1'b0;
      end else begin
        unique case (state_reg)
          ST_WAITVIN: begin
            state_reg <= ST_EVAL;
          end
          ST_EVAL: begin
            // Sampled once per reset or turn-on attempt
            firstEval_reg <= 1'b1;
            idx_reg <= '0;
            if (fuseHigh) begin
              // Factory defaults regardless of flags
              src_reg <= SRC_DEFAULT;
              state_reg <= ST_DEF;
              busy_reg <= 1'b1;
            end else if (keepShadowFlag) begin
              // Shadow contents kept as they are
              src_reg <= SRC_SHADOW;
              state_reg <= ST_READY;
            end else if (fuseFlag) begin
              // Fuse copy
              src_reg <= SRC_FUSE;
              state_reg <= ST_FUSE;
              busy_reg <= 1'b1;
            end else begin
              // No source, shadow left at zero
              src_reg <= SRC_NONE;
              state_reg <= ST_READY;
            end
          end
          ST_FUSE, ST_DEF: begin
            // One bank per cycle over all banks
            if (idx_reg == LAST_BANK) begin
              state_reg <= ST_READY;
              busy_reg <= 1'b0;
            end else begin
              idx_reg <= idx_reg + 1'b1;
            end
          end
          ST_READY: begin
            if (pendingOn_reg) begin
              pendingOn_reg <= 1'b0;
              if (src_reg != SRC_NONE) begin
                // Power up from the loaded source
                powered_reg <= 1'b1;
                state_reg <= ST_ON;
              end
            end else if (btnOn) begin
              // Turn-on re-evaluates the source first
              pendingOn_reg <= 1'b1;
              state_reg <= ST_EVAL;
            end
          end
          ST_ON: begin
            if (btnOff) begin
              powered_reg <= 1'b0;
              state_reg <= ST_READY;
            end
          end
        endcase
      end
    end
  end

  // Shadow register file
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // Cleared by reset, whatever the supply
      for (int i = 0; i < BANKS; i++) begin
        shadowMem[i] <= ZERO_WORD;
      end
    end else if (ce && vinOk) begin
      if (state_reg == ST_EVAL && !fuseHigh && !keepShadowFlag
          && !fuseFlag) begin
        for (int i = 0; i < BANKS; i++) begin
          shadowMem[i] <= ZERO_WORD;
        end
      end else if (state_reg == ST_FUSE) begin
        // Corrected or raw fuse word
        shadowMem[idx_reg] <= eccEnabled ? fuseEccData : fuseRawData;
      end else if (state_reg == ST_DEF) begin
        shadowMem[idx_reg] <= default_word(idx_reg);
      end else if (hostOpen && hostWrEn && hostAddr <= LAST_BANK) begin
        shadowMem[hostAddr] <= hostWrData;
      end
    end
  end

  // Host readback; unmapped addresses read zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_reg <= ZERO_WORD;
    end else if (ce) begin
      rdData_reg <= (hostAddr <= LAST_BANK) ? shadowMem[hostAddr]
                                            : ZERO_WORD;
    end
  end

  // Outputs straight from flops
  assign hostRdData = rdData_reg;
  assign fuseAddr = idx_reg;
  assign configSource = src_reg;
  assign loadBusy = busy_reg;
  assign poweredOn = powered_reg;
  assign clk2mTick = clk2m_reg;
  assign derivedTick = derived_reg;
  assign untrimmedTick = untrimmed_reg;
  assign mainTick = main_reg;
  assign irqDebTick = irqDeb_reg;
  assign slowIrqTick = slowIrq_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic shadowZero; // Helper: all shadow words zero
  always_comb begin
    shadowZero = 1'b1;
    for (int i = 0; i < BANKS; i++) begin
      if (shadowMem[i] != ZERO_WORD) shadowZero = 1'b0;
    end
  end

  a_zero_before_load: assert property (
    !firstEval_reg |-> shadowZero)
    else $error("shadow not zero before first load");
  a_default_wins: assert property (
    ce && vinOk && state_reg == ST_EVAL && fuseHigh
      |=> state_reg == ST_DEF ##[1:20] state_reg == ST_READY)
    else $error("defaults not loaded with fuse supply high");
  a_fuse_selected: assert property (
    ce && vinOk && state_reg == ST_EVAL && !fuseHigh && !keepShadowFlag
      && fuseFlag |=> state_reg == ST_FUSE && src_reg == SRC_FUSE)
    else $error("fuse load not chosen");
  a_xor_single_flag: assert property (
    ce && vinOk && state_reg == ST_EVAL && !fuseHigh && !keepShadowFlag
      && !revisedVariant && fuseLoadFlagOne && !fuseLoadFlagTwo
      && !fuseLoadFlagThree |=> state_reg == ST_FUSE)
    else $error("single flag did not enable fuse load");
  a_revised_needs_all: assert property (
    ce && vinOk && state_reg == ST_EVAL && revisedVariant
      && !(fuseLoadFlagOne && fuseLoadFlagTwo && fuseLoadFlagThree)
      |=> state_reg != ST_FUSE)
    else $error("fuse load without all flags");
  a_none_stays_zero: assert property (
    ce && vinOk && state_reg == ST_EVAL && !fuseHigh && !keepShadowFlag
      && !fuseFlag |=> shadowZero && src_reg == SRC_NONE)
    else $error("shadow not zero without a source");
  a_keep_retains: assert property (
    ce && vinOk && state_reg == ST_EVAL && !fuseHigh && keepShadowFlag
      |=> $stable(shadowMem[0]) && state_reg == ST_READY)
    else $error("shadow reloaded with keep flag set");
  a_power_needs_source: assert property (
    $rose(powered_reg) |-> vinOk && src_reg != SRC_NONE
      && $past(state_reg) == ST_READY)
    else $error("power-up without a loaded source");
  // Helper: enabled cycles spent in the fuse load
  logic [AW-1:0] fuseCyc_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fuseCyc_reg <= '0;
    end else if (ce) begin
      fuseCyc_reg <= (state_reg == ST_FUSE) ? fuseCyc_reg + 1'b1 : '0;
    end
  end

  a_fuse_banks_len: assert property (
    $past(state_reg) == ST_FUSE && state_reg == ST_READY
      |-> fuseCyc_reg == AW'(BANKS))
    else $error("fuse load not ten banks long");
  a_two_mhz_rate: assert property (
    ce && osc16Tick && div2m_reg == TWO_LAST |=> clk2m_reg
      ##1 (!clk2m_reg || !$past(ce)))
    else $error("2 MHz tick wrong");

  c_fuse_power_on: cover property (
    state_reg == ST_FUSE ##[1:40] $rose(powered_reg));
  c_shadow_power_on: cover property (
    src_reg == SRC_SHADOW && $rose(powered_reg));
  c_default_load: cover property ($rose(state_reg == ST_DEF));
endmodule : ocs_loader
`default_nettype wire

// *** sim/ocs_fuse_model.sv ***
// Fuse array model for the loader's fuse read port.
// Assumes a combinational lookup on the bank index from the loader.
`timescale 1ns/1ps
`default_nettype none
module ocs_fuse_model
  import ocs_pkg::*;
(
  // Bank select
  input wire logic [AW-1:0] fuseAddr,
  // Bank contents
  output logic [BANK_BITS-1:0] fuseRawData,
  output logic [BANK_BITS-1:0] fuseEccData
);
  // Ten banks of twenty-six bits; beyond them a toggled pattern
  always_comb begin
    if (fuseAddr <= LAST_BANK) begin
      fuseRawData = {fuseAddr, 22'h15a3c7};
    end else begin
      fuseRawData = ~{fuseAddr, 22'h15a3c7};
    end
    // Corrected word differs from the raw one in one bit
    fuseEccData = fuseRawData ^ (26'h1 << fuseAddr);
  end
endmodule : ocs_fuse_model
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench for the configuration source loader.
// Assumes the fuse model on the fuse port and a host driven from here.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ocs_pkg::*;
;
  localparam int HOLDT = 5; // Short long-press count
  logic clk = 1'b0;
  logic rst, vinValidPin, belowUvPin, fuseSupplyPin, powerOnPin;
  logic slowOscPin = 1'b0;
  logic ce = 1'b1; // Clock enable, dropped once to freeze the loader
  logic osc16OnMode, allSleep, allPfm, keepShadowFlag, revisedVariant;
  logic buttonEdgeModeSelect, eccEnabled, hostWrEn;
  logic [2:0] flags; // Three fuse-load flags
  logic [AW-1:0] hostAddr, fuseAddr;
  logic [BANK_BITS-1:0] hostWrData, hostRdData, fuseRawData, fuseEccData;
  logic [1:0] configSource;
  logic loadBusy, poweredOn, clk2mTick, derivedTick, untrimmedTick;
  logic mainTick, irqDebTick, slowIrqTick;
  int error_cnt = 0;
  int compares = 0;
  int cnt [6]; // Tick counts of one window
  integer seed = 32'h5f552700;
  logic [BANK_BITS-1:0] shadow [BANKS]; // Expected shadow words

  // Clocks: system and free untrimmed oscillator
  always #20 clk = ~clk;
  always #810 slowOscPin = ~slowOscPin;

  ocs_loader #(.HOLD(HOLDT)) u_dut (
    .clk, .rst, .ce, .vinValidPin, .belowUvPin, .fuseSupplyPin,
    .powerOnPin, .slowOscPin, .osc16Tick(1'b1), .osc16OnMode, .allSleep,
    .allPfm, .keepShadowFlag, .fuseLoadFlagOne(flags[0]),
    .fuseLoadFlagTwo(flags[1]), .fuseLoadFlagThree(flags[2]),
    .revisedVariant, .buttonEdgeModeSelect, .eccEnabled, .hostWrEn,
    .hostAddr, .hostWrData, .hostRdData, .fuseAddr, .fuseRawData,
    .fuseEccData, .configSource, .loadBusy, .poweredOn, .clk2mTick,
    .derivedTick, .untrimmedTick, .mainTick, .irqDebTick, .slowIrqTick
  );
  ocs_fuse_model u_fuse (.fuseAddr, .fuseRawData, .fuseEccData);

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // Compare tasks, one per kind of result
  task automatic chkWord(input logic [BANK_BITS-1:0] got, exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t word %h exp %h", $time, got, exp);
    end
  endtask : chkWord
  task automatic chkSrc(input logic [1:0] got, exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t source %h exp %h", $time, got, exp);
    end
  endtask : chkSrc
  task automatic chkBit(input logic got, exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t flag %b exp %b", $time, got, exp);
    end
  endtask : chkBit
  task automatic chkCnt(input int got, exp, tol);
    compares++;
    if (got < exp - tol || got > exp + tol) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t count %0d exp %0d", $time, got, exp);
    end
  endtask : chkCnt

  // Expected source from pin level and flags
  function automatic logic [1:0] expSrc(input logic f, k,
                                        input logic [2:0] fl,
                                        input logic r);
    if (f) return 2'h3;
    if (k) return 2'h2;
    if (r ? &fl : ^fl) return 2'h1;
    return 2'h0;
  endfunction : expSrc

  // Expected fuse word of one bank, raw or corrected
  function automatic logic [BANK_BITS-1:0] fuseWord(input int i);
    logic [AW-1:0] a;
    a = AW'(i);
    return {a, 22'h15a3c7} ^ (eccEnabled ? 26'h1 << i : 26'h0);
  endfunction : fuseWord

  // Update expected words after a load from a source
  task automatic loadExp(input logic [1:0] s);
    for (int i = 0; i < BANKS; i++) begin
      if (s == 2'h3) shadow[i] = DEFAULT_SEED ^ BANK_BITS'(i);
      if (s == 2'h1) shadow[i] = fuseWord(i);
    end
  endtask : loadExp

  // Read every bank plus two unmapped addresses
  task automatic readAll();
    for (int i = 0; i < 12; i++) begin
      hostAddr = AW'(i);
      @(negedge clk);
      chkWord(hostRdData, i < BANKS ? shadow[i] : '0);
    end
  endtask : readAll

  // One host write pulse
  task automatic hostWrite(input int a, input logic [BANK_BITS-1:0] d);
    @(negedge clk);
    hostWrEn = 1'b1;
    hostAddr = AW'(a);
    hostWrData = d;
    if (a < BANKS) shadow[a] = d;
    @(negedge clk);
    hostWrEn = 1'b0;
  endtask : hostWrite

  // Reset, apply supply, let the loader pick its source
  task automatic boot(input logic f, k, input logic [2:0] fl,
                      input logic r);
    int nb;
    logic [1:0] s;
    @(negedge clk);
    rst = 1'b1;
    vinValidPin = 1'b0;
    powerOnPin = buttonEdgeModeSelect;
    fuseSupplyPin = f;
    keepShadowFlag = k;
    flags = fl;
    revisedVariant = r;
    eccEnabled = 1'($random(seed));
    repeat (12) @(negedge clk);
    chkSrc(configSource, 2'h0);
    chkBit(poweredOn, 1'b0);
    rst = 1'b0;
    vinValidPin = 1'b1;
    nb = 0;
    repeat (30) begin
      @(negedge clk);
      nb += int'(loadBusy === 1'b1);
    end
    s = expSrc(f, k, fl, r);
    chkSrc(configSource, s);
    chkCnt(nb, (s == 2'h1 || s == 2'h3) ? BANKS : 0, 0);
    for (int i = 0; i < BANKS; i++) shadow[i] = '0;
    loadExp(s);
    readAll();
  endtask : boot

  // Make a turn-on event, wait a bounded time for power-up
  task automatic turnOn(output int nb);
    nb = 0;
    powerOnPin = ~buttonEdgeModeSelect;
    for (int i = 0; i < 60 && poweredOn !== 1'b1; i++) begin
      @(negedge clk);
      nb += int'(loadBusy === 1'b1);
    end
  endtask : turnOn

  // Count every tick output over a fixed window
  task automatic measure();
    cnt = '{default: 0};
    repeat (4000) begin
      @(negedge clk);
      cnt[0] += int'(clk2mTick === 1'b1);
      cnt[1] += int'(derivedTick === 1'b1);
      cnt[2] += int'(untrimmedTick === 1'b1);
      cnt[3] += int'(mainTick === 1'b1);
      cnt[4] += int'(irqDebTick === 1'b1);
      cnt[5] += int'(slowIrqTick === 1'b1);
    end
  endtask : measure

  // Watchdog against a hang
  initial begin
    #(40 * 60000);
    error_cnt++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    int nb;
    logic [5:0] p;
    {rst, vinValidPin, belowUvPin, fuseSupplyPin, powerOnPin} = 5'h10;
    {osc16OnMode, allSleep, allPfm, keepShadowFlag, flags} = 7'h40;
    {revisedVariant, buttonEdgeModeSelect, eccEnabled, hostWrEn} = 4'h0;
    hostAddr = '0;
    hostWrData = '0;
    // Every source table row with fuse supply low in both variants, the sixteen with it high and keep clear, then random rows
    for (int i = 0; i < 56; i++) begin
      p = (i < 48) ? 6'(i) : 6'($random(seed));
      boot(p[5], p[4], p[2:0], p[3]);
    end
    // Trial words kept and used for power-up
    boot(1'b0, 1'b1, 3'h7, 1'b0);
    for (int i = 0; i < 12; i++) hostWrite(i, 26'($random(seed)));
    readAll();
    // Frozen by the enable: a pin change does nothing yet
    ce = 1'b0;
    powerOnPin = 1'b1;
    repeat (20) @(negedge clk);
    chkBit(poweredOn, 1'b0);
    ce = 1'b1;
    turnOn(nb);
    chkBit(poweredOn, 1'b1);
    chkCnt(nb, 0, 0);
    chkSrc(configSource, 2'h2);
    readAll();
    powerOnPin = 1'b0;
    repeat (20) @(negedge clk);
    chkBit(poweredOn, 1'b0);
    // Fuse reload before the next power-up, revised variant
    keepShadowFlag = 1'b0;
    flags = 3'h7;
    revisedVariant = 1'b1;
    eccEnabled = 1'b1;
    turnOn(nb);
    chkBit(poweredOn, 1'b1);
    chkSrc(configSource, 2'h1);
    chkCnt(nb, BANKS, 0);
    loadExp(2'h1);
    readAll();
    powerOnPin = 1'b0;
    repeat (20) @(negedge clk);
    // No source: a turn-on attempt stays off
    flags = 3'h3;
    turnOn(nb);
    chkBit(poweredOn, 1'b0);
    powerOnPin = 1'b0;
    // Edge mode: fall starts, long hold stops
    buttonEdgeModeSelect = 1'b1;
    boot(1'b0, 1'b1, 3'h0, 1'b0);
    turnOn(nb);
    chkBit(poweredOn, 1'b1);
    nb = 0;
    while (poweredOn === 1'b1 && nb < 4000) begin
      @(negedge clk);
      nb++;
    end
    chkCnt(nb, HOLDT * 500, 600);
    buttonEdgeModeSelect = 1'b0;
    powerOnPin = 1'b0;
    // Time bases with the trimmed oscillator in charge
    measure();
    chkCnt(cnt[0], 500, 1);
    chkCnt(cnt[1], 8, 1);
    chkCnt(cnt[2], 99, 2);
    chkCnt(cnt[3], 8, 1);
    chkCnt(cnt[4], 8, 1);
    chkCnt(cnt[5], 99, 2);
    // One low-power condition picked at random, oscillator not on
    p = 6'($random(seed));
    osc16OnMode = 1'b0;
    {belowUvPin, allSleep, allPfm} = 3'h1 << (p % 3);
    measure();
    chkCnt(cnt[3], 99, 2);
    chkCnt(cnt[4], 99, 2);
    chkCnt(cnt[5], 99, 2);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
